// ===== verilog/mscb_pkg.sv
// Package of the module sideband control block: constants, states, carriers.
// Assumes a single 200 MHz system clock and synchronous active-high reset.
package mscb_pkg;

  // Clock period in picoseconds
  localparam int CLK_PERIOD_PS = 5000;

  // Least reset pulse width on the module reset pin, in nanoseconds
  localparam int RESET_MIN_NS = 10000;
  localparam int RESET_MIN_CYC =
    (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Initialisation interval after reset release, in microseconds
  localparam int INIT_US = 2000;
  localparam int INIT_CYC = (INIT_US * 1000000) / CLK_PERIOD_PS;

  // Synchroniser depth
  localparam int SYNC_STAGES = 2;

  // Reset values of the sampled pins, pull-ups applied to select and reset, low power resets low
  localparam logic SELECT_N_RST = 1'h1;
  localparam logic RESET_N_RST = 1'h1;
  localparam logic LOW_POWER_RST = 1'h0;

  // Status bit positions reported to the management bus logic
  localparam int ST_INIT_PENDING = 0;
  localparam int ST_LOW_POWER = 1;
  localparam int ST_SELECTED = 2;
  localparam int ST_WIDTH = 3;

  typedef enum logic [2:0] {
    MSCB_INIT = 3'h1,
    MSCB_RUN = 3'h2,
    MSCB_HOLD = 3'h4
  } mscb_state_e;

  // Pins from the host, already raw
  typedef struct packed {
    logic selectN;
    logic resetN;
    logic lowPower;
  } mscb_pins_s;

  // Events from the core that call for host attention
  typedef struct packed {
    logic fault;
    logic critical;
  } mscb_event_s;

endpackage

// ===== verilog/mscb_sync.sv
// Two-flop synchroniser for a group of host pins.
// Assumes the pins are quasi-static relative to sys_clk.
`timescale 1ns/100ps
module mscb_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  import mscb_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } mscb_sync_s;

  mscb_sync_s st;
  mscb_sync_s next_st;

  initial begin
    if (WIDTH < 1) $error("mscb_sync: WIDTH must be positive");
  end

  // First stage feeds only the second stage
  always_comb begin
    next_st.meta = din;
    next_st.stable = st.meta;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= {RST_VAL, RST_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.stable;
endmodule // mscb_sync

// ===== verilog/mscb_filter.sv
// Pulse-width qualifier: a low level counts only after MIN_CYC cycles.
// Assumes a synchronised input.
`timescale 1ns/100ps
module mscb_filter #(
  parameter int MIN_CYC = 2000
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic levelN,
  output logic qualified
);
  import mscb_pkg::*;

  localparam int CW = $clog2(MIN_CYC + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic hit;
  } mscb_filt_s;

  mscb_filt_s st;
  mscb_filt_s next_st;

  initial begin
    if (MIN_CYC < 1) $error("mscb_filter: MIN_CYC must be at least 1");
  end

  always_comb begin
    next_st = st;
    if (levelN) begin
      next_st.cnt = '0;
      next_st.hit = 1'b0;
    end else if (st.cnt != CW'(MIN_CYC)) begin
      next_st.cnt = st.cnt + CW'(1);
    end else begin
      next_st.hit = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign qualified = st.hit;
endmodule // mscb_filter

// ===== verilog/module_sideband_control.sv
// Sideband control of a pluggable module: select, reset, low power,
// presence and attention pins. Assumes host pins synchronous-capable,
// an external 2-wire engine that honours busEnable, and a host pull-up.
`timescale 1ns/100ps

module module_sideband_control #(
  parameter int RESET_MIN = mscb_pkg::RESET_MIN_CYC,
  parameter int INIT_TIME = mscb_pkg::INIT_CYC
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire mscb_pkg::mscb_pins_s hostPins,
  input wire logic selectDriven,
  input wire mscb_pkg::mscb_event_s coreEvent,
  input wire logic statusRead,
  output logic busEnable,
  output logic userReset,
  output logic lowPowerMode,
  output logic [mscb_pkg::ST_WIDTH-1:0] status,
  output logic presence_n_o,
  output logic presence_n_oe,
  output logic attention_n_o,
  output logic attention_n_oe
);
  import mscb_pkg::*;

  localparam int IW = $clog2(INIT_TIME + 1);

  typedef struct packed {
    mscb_state_e state;
    logic [IW-1:0] initCnt;
    logic pending;
    logic busEnable;
    logic userReset;
    logic lowPowerMode;
    logic [ST_WIDTH-1:0] status;
    logic presenceOe;
    logic attentionOe;
  } mscb_top_s;

  mscb_top_s st;
  mscb_top_s next_st;
  mscb_pins_s pinsIn;
  mscb_pins_s pinsSync;
  logic resetHit;

  initial begin
    if (RESET_MIN < 1) $error("RESET_MIN must be at least 1");
    if (INIT_TIME < 1) $error("INIT_TIME must be at least 1");
  end

  // Floating select is pulled high inside the module
  always_comb begin
    pinsIn = hostPins;
    if (!selectDriven) begin
      pinsIn.selectN = 1'b1;
    end
  end

  mscb_sync #(
    .WIDTH(3),
    .RST_VAL({SELECT_N_RST, RESET_N_RST, LOW_POWER_RST})
  ) u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .din(pinsIn),
    .dout(pinsSync)
  );

  // Short glitches on the reset pin never start a reset
  mscb_filter #(
    .MIN_CYC(RESET_MIN)
  ) u_filter (
    .sys_clk(sys_clk),
    .srst(srst),
    .levelN(pinsSync.resetN),
    .qualified(resetHit)
  );

  always_comb begin
    next_st = st;
    next_st.presenceOe = 1'b1;
    next_st.lowPowerMode = pinsSync.lowPower;
    unique case (st.state)
      MSCB_HOLD: begin
        // Defaults held while reset pin stays low
        next_st.userReset = 1'b1;
        next_st.busEnable = 1'b0;
        next_st.status[ST_INIT_PENDING] = 1'b1;
        next_st.pending = 1'b0;
        next_st.initCnt = '0;
        if (pinsSync.resetN) begin
          next_st.state = MSCB_INIT;
        end
      end
      MSCB_INIT: begin
        next_st.userReset = 1'b0;
        next_st.status[ST_INIT_PENDING] = 1'b1;
        if (st.initCnt == IW'(INIT_TIME - 1)) begin
          next_st.state = MSCB_RUN;
          next_st.status[ST_INIT_PENDING] = 1'b0;
          next_st.pending = 1'b1;
        end else begin
          next_st.initCnt = st.initCnt + IW'(1);
        end
      end
      MSCB_RUN: begin
        next_st.userReset = 1'b0;
        // Event sets win over a same-cycle status read
        if (coreEvent.fault || coreEvent.critical) begin
          next_st.pending = 1'b1;
        end else if (statusRead && !pinsSync.selectN) begin
          next_st.pending = 1'b0;
        end
      end
      default: begin
        next_st.state = MSCB_HOLD;
      end
    endcase
    // Bus answers only while selected and not in reset
    next_st.busEnable = !pinsSync.selectN && st.state != MSCB_HOLD
      && !resetHit;
    next_st.status[ST_LOW_POWER] = pinsSync.lowPower;
    next_st.status[ST_SELECTED] = !pinsSync.selectN;
    // Open drain: enable pulls low, never drives high
    next_st.attentionOe = next_st.pending;
    if (resetHit) begin
      next_st.state = MSCB_HOLD;
      next_st.userReset = 1'b1;
      next_st.busEnable = 1'b0;
      next_st.attentionOe = 1'b0;
      next_st.pending = 1'b0;
      // Pending from the qualifying edge, so it never falls into a reset
      next_st.status[ST_INIT_PENDING] = 1'b1;
    end
  end

  // Power-up starts in the init interval so completion posts unprompted
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= '0;
      st.state <= MSCB_INIT;
      st.userReset <= 1'b1;
      st.status <= ST_WIDTH'(1);
    end else begin
      st <= next_st;
    end
  end

  assign busEnable = st.busEnable;
  assign userReset = st.userReset;
  assign lowPowerMode = st.lowPowerMode;
  assign status = st.status;
  assign presence_n_o = 1'b0;
  assign presence_n_oe = st.presenceOe;
  assign attention_n_o = 1'b0;
  assign attention_n_oe = st.attentionOe;
endmodule // module_sideband_control

// ===== verif/mscb_host_board.sv
// Host board model: pull-ups on the presence and attention lines.
// Assumes open-drain outputs, enable high while pulling low.
`timescale 1ns/100ps
module mscb_host_board (
  input wire logic presO,
  input wire logic presOe,
  input wire logic attnO,
  input wire logic attnOe,
  output logic presLevel,
  output logic attnLevel
);
  // Released lines float up to the supply
  assign presLevel = presOe ? presO : 1'h1;
  assign attnLevel = attnOe ? attnO : 1'h1;
endmodule // mscb_host_board

// ===== verif/mscb_sideband_assertions.sv
// Port checks of the sideband control block, bound below.
// Assumes the one clock sys_clk and srst active high.
`timescale 1ns/100ps
module mscb_checker #(
  parameter int RESET_MIN = 4,
  parameter int INIT_TIME = 20
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire mscb_pkg::mscb_pins_s hostPins,
  input wire logic selectDriven,
  input wire mscb_pkg::mscb_event_s coreEvent,
  input wire logic statusRead,
  input wire logic busEnable,
  input wire logic userReset,
  input wire logic lowPowerMode,
  input wire logic [mscb_pkg::ST_WIDTH-1:0] status,
  input wire logic presence_n_o,
  input wire logic presence_n_oe,
  input wire logic attention_n_o,
  input wire logic attention_n_oe
);
  import mscb_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // A floating select reads as deselected
  wire logic deselected = hostPins.selectN || !selectDriven;
  a_select_answer: assert property ((!deselected && !userReset)[*3]
    |=> busEnable || userReset) else $error("bus not enabled");
  a_select_quiet: assert property (deselected[*3] |=> !busEnable)
    else $error("bus enabled while deselected");
  a_reset_qualify: assert property ($rose(userReset)
    |-> !$past(hostPins.resetN, 4) && !$past(hostPins.resetN, 5))
    else $error("reset taken from a short pulse");
  a_init_done: assert property ($fell(status[ST_INIT_PENDING])
    |-> attention_n_oe && !userReset) else $error("no completion flag");
  a_low_power: assert property (hostPins.lowPower[*3]
    |=> lowPowerMode && status[ST_LOW_POWER]) else $error("no low power");
  a_event_flag: assert property ((|coreEvent) && !userReset
    && !status[ST_INIT_PENDING] |=> attention_n_oe) else $error("no flag");
  a_attn_only_low: assert property (attention_n_oe |-> !attention_n_o)
    else $error("attention driven high");
  a_presence_held: assert property (!$past(srst)
    |-> presence_n_oe && !presence_n_o) else $error("presence released");
  c_done: cover property ($fell(status[ST_INIT_PENDING]));
  c_reset: cover property ($rose(userReset));
  c_clear: cover property ($fell(attention_n_oe));
endmodule // mscb_checker

bind module_sideband_control mscb_checker #(.RESET_MIN(RESET_MIN),
  .INIT_TIME(INIT_TIME)) u_chk (.sys_clk(sys_clk), .srst(srst),
  .hostPins(hostPins), .selectDriven(selectDriven), .coreEvent(coreEvent),
  .statusRead(statusRead), .busEnable(busEnable), .userReset(userReset),
  .lowPowerMode(lowPowerMode), .status(status),
  .presence_n_o(presence_n_o), .presence_n_oe(presence_n_oe),
  .attention_n_o(attention_n_o), .attention_n_oe(attention_n_oe));

// ===== verif/tb_module_sideband_control.sv
// Self-checking bench of the sideband control block and host board.
// Assumes shortened counts: reset width 4, init interval 20 cycles.
`timescale 1ns/100ps
module tb_module_sideband_control;
  import mscb_pkg::*;
  localparam int RMIN = 4;
  localparam int TINIT = 20;
  typedef struct packed {
    logic [2:0] pin;
    logic [1:0] exp;
  } mscb_row_s;
  // Pins are {selectN, selectDriven, lowPower}
  mscb_row_s rows [4] = '{'{3'h2, 2'h2}, '{3'h7, 2'h1}, '{3'h1, 2'h1},
    '{3'h3, 2'h3}};
  logic sys_clk = 1'h0;
  logic srst = 1'h1;
  mscb_pins_s hostPins = 3'h6;
  logic selectDriven = 1'h1;
  mscb_event_s coreEvent = 2'h0;
  logic statusRead = 1'h0;
  logic busEnable, userReset, lowPowerMode, presO, presOe, attnO, attnOe;
  logic presLevel, attnLevel;
  logic [ST_WIDTH-1:0] status;
  int failures = 0;
  int cmp_count = 0;
  int n;
  module_sideband_control #(.RESET_MIN(RMIN), .INIT_TIME(TINIT)) dut (
    .sys_clk(sys_clk), .srst(srst), .hostPins(hostPins),
    .selectDriven(selectDriven), .coreEvent(coreEvent),
    .statusRead(statusRead), .busEnable(busEnable), .userReset(userReset),
    .lowPowerMode(lowPowerMode), .status(status), .presence_n_o(presO),
    .presence_n_oe(presOe), .attention_n_o(attnO), .attention_n_oe(attnOe));
  mscb_host_board host (.presO(presO), .presOe(presOe), .attnO(attnO),
    .attnOe(attnOe), .presLevel(presLevel), .attnLevel(attnLevel));
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic waitAttn(input int lim);
    n = 0;
    while (attnLevel !== 1'h0 && n < lim) begin
      cyc(1);
      #1;
      n++;
    end
  endtask
  task automatic readStatus();
    cyc(1);
    statusRead <= 1'h1;
    cyc(1);
    statusRead <= 1'h0;
    cyc(3);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    tally_and_finish();
  end
  initial begin
    cyc(3);
    #1;
    chk({userReset, status}, 4'h9);
    cyc(5);
    srst <= 1'h0;
    waitAttn(TINIT + 20);
    chk({attnLevel, status[0], presLevel, 1'h0}, 4'h0);
    foreach (rows[i]) begin
      cyc(1);
      {hostPins.selectN, selectDriven, hostPins.lowPower} <= rows[i].pin;
      cyc(5);
      #1;
      chk({busEnable, lowPowerMode, status[2:1]}, {2{rows[i].exp}});
    end
    readStatus();
    chk({3'h0, attnLevel}, 4'h1);
    for (int e = 1; e < 3; e++) begin
      cyc(1);
      coreEvent <= 2'(e);
      cyc(1);
      coreEvent <= 2'h0;
      cyc(2);
      #1;
      chk({3'h0, attnLevel}, 4'h0);
      cyc(1);
      hostPins.selectN <= 1'h1;
      // Let the new select level pass the two synchroniser flops
      cyc(2);
      readStatus();
      chk({3'h0, attnLevel}, 4'h0);
      cyc(1);
      hostPins.selectN <= 1'h0;
      cyc(2);
      readStatus();
      chk({3'h0, attnLevel}, 4'h1);
    end
    cyc(1);
    hostPins.resetN <= 1'h0;
    cyc(RMIN - 1);
    hostPins.resetN <= 1'h1;
    cyc(12);
    #1;
    chk({3'h0, userReset}, 4'h0);
    cyc(1);
    hostPins.resetN <= 1'h0;
    cyc(12);
    #1;
    chk({userReset, busEnable, attnLevel, 1'h0}, 4'hA);
    cyc(1);
    hostPins.resetN <= 1'h1;
    cyc(TINIT / 2);
    #1;
    chk({3'h0, status[0]}, 4'h1);
    waitAttn(TINIT);
    chk({3'h0, n + TINIT / 2 >= TINIT && n <= TINIT / 2 + 6}, 4'h1);
    chk({status[0], userReset, attnLevel, 1'h0}, 4'h0);
    tally_and_finish();
  end
endmodule // tb_module_sideband_control
